//--- logic/cdg_pkg.sv
package cdg_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [31:0] OFS_SRC_DIS = 32'hffffe030;
  localparam logic [31:0] OFS_DOM_DIS = 32'hffffe03c;
  localparam logic [31:0] OFS_MAIN_SRC = 32'hffffe048;
  localparam logic [31:0] OFS_ASYNC_SRC = 32'hffffe04c;
  localparam logic [31:0] OFS_OST_SRC = 32'hffffe050;
  localparam logic [31:0] OFS_PLL1_A = 32'hffffe070;
  localparam logic [31:0] OFS_PLL1_B = 32'hffffe074;
  localparam logic [31:0] OFS_SELF_TEST_DIV = 32'hffffe108;
  localparam logic [31:0] OFS_ACON1 = 32'hffffe140;
  localparam logic [31:0] OFS_PLL2 = 32'hffffe0c8;
  localparam logic [31:0] OFS_PDIV = 32'hffffe0d0;
  localparam logic [31:0] OFS_STATUS = 32'hffffe0ec;

  // Reset values
  localparam logic [7:0] SRC_DIS_RST = 8'hce;
  localparam logic [11:0] DOM_DIS_RST = 12'h000;
  localparam logic [2:0] MAIN_SRC_RST = 3'h0;
  localparam logic [31:0] ASYNC_SRC_RST = 32'h00000909;
  localparam logic [31:0] OST_SRC_RST = 32'h00000009;
  localparam logic [31:0] ACON1_RST = 32'h00090109;
  localparam logic [31:0] ZERO_RST = 32'h00000000;

  // Selector code standing for the primary peripheral clock
  localparam logic [3:0] SEL_PERIPH = 4'h9;

  // Domain disable bit positions
  localparam int DD_CPU = 0;
  localparam int DD_BUS = 1;
  localparam int DD_P1 = 2;
  localparam int DD_P2 = 3;
  localparam int DD_A1 = 4;
  localparam int DD_A2 = 5;
  localparam int DD_OST = 6;
  localparam int DD_P3 = 8;
  localparam int DD_A3 = 10;
  localparam int DD_A4 = 11;

  // Field positions
  localparam int ASRC_A1_LSB = 0;
  localparam int ASRC_A2_LSB = 8;
  localparam int ACON_A3SEL_LSB = 0;
  localparam int ACON_GATE = 4;
  localparam int ACON_DIV_LSB = 8;
  localparam int ACON_A4SEL_LSB = 16;
  localparam int OST_SEL_LSB = 0;
  localparam int OST_PRE_LSB = 8;
  localparam int PDIV_STRIDE = 8;
  localparam int STC_DIV_LSB = 0;
  localparam int PLL_SLIPRST = 31;
  localparam int PLL_FM = 31;
  localparam int PLL_MULT_LSB = 8;
  localparam int PLL_DIV_LSB = 0;
  localparam int STAT_SLIP1 = 8;
  localparam int STAT_SLIP2 = 9;

  // Peripheral division codes
  localparam logic [1:0] PDIV_BY1 = 2'h0;
  localparam logic [1:0] PDIV_BY2 = 2'h1;
  localparam logic [1:0] PDIV_BY16 = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cdg_req_t;

  typedef struct packed {
    logic bus;
    logic cpu;
    logic cpu_dly;
    logic p1;
    logic p2;
    logic p3;
    logic a1;
    logic a2;
    logic a3s;
    logic a3d;
    logic a4;
    logic ost;
  } cdg_tick_t;

  typedef struct packed {
    logic fm_en;
    logic slip_rst_en;
    logic [7:0] mult;
    logic [2:0] prediv;
    logic [2:0] postdiv;
  } cdg_pll_cfg_t;

endpackage

//--- logic/cdg_divider.sv
`timescale 1ns/1ps
module cdg_divider #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic in_tick,
  input wire logic [W-1:0] div,
  output logic out_tick
);
  logic [W-1:0] cnt;

  // New divide values load only at wrap, so only a clear cuts a period short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (in_tick) begin
      cnt <= (cnt == '0) ? div : cnt - 1'b1;
    end
  end

  assign out_tick = in_tick && (cnt == '0);

  chk_div_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    (out_tick && !clr) |=> (cnt == $past(div)))
    else $error("divider did not reload on wrap");
endmodule // cdg_divider

//--- logic/cdg_slip_monitor.sv
`timescale 1ns/1ps
module cdg_slip_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slip,
  input wire logic clr,
  input wire logic reset_en,
  output logic flag,
  output logic reset_req
);
  // A slip in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (slip) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_req <= 1'b0;
    end else begin
      reset_req <= slip && reset_en;
    end
  end

  chk_slip_sticky: assert property (
    @(posedge clk) disable iff (!rst_b) slip |=> flag)
    else $error("slip not latched");
endmodule // cdg_slip_monitor

//--- logic/cdg_top.sv
// Operation
// - CPU clock in phase with bus clock; bit 0 gates CPU, bit 1 bus.
// - During self-test the CPU clock divides by 1 to 8 from its field.
// - Delayed CPU clock has CPU frequency and lags it by two cycles.
// - Delayed CPU clock shares the CPU gate and self-test division.
// - Each peripheral clock is bus clock divided by 1, 2 or 16.
// - Bits 2, 3 and 8 gate the three peripheral clocks independently.
// - Async clocks one and two default to primary peripheral; bits 4, 5.
// - Async three source: primary peripheral default, up to bus rate, bit 10.
// - Async three divided clock is its source divided by 1 to 8.
// - After reset async three divided clock runs at half its source.
// - Own gate bit stops async three divided clock while its source runs.
// - Async clock four defaults to primary peripheral; bit 11 gates it.
// - OS-timer clock defaults to primary peripheral; bit 6 gates it.
// - Each domain picks its source; main domains share one selector.
// - First PLL may modulate frequency; second PLL never modulates.
// - Each PLL has slip monitoring; option resets device on slip.
// - Two registers configure the first PLL, a third the second.
// - Each source has its own disable bit at its source number.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module cdg_top
  import cdg_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire cdg_req_t REG_REQ,
  output logic [DATA_W-1:0] RD_DATA,
  input wire logic [7:0] SRC_TICK,
  input wire logic SELF_TEST_ACTIVE,
  input wire logic PLL1_SLIP,
  input wire logic PLL2_SLIP,
  output cdg_tick_t DOMAIN_TICK,
  output logic [7:0] SRC_ENABLE,
  output cdg_pll_cfg_t PLL1_CFG,
  output cdg_pll_cfg_t PLL2_CFG,
  output logic DEVICE_RESET_REQ
);

  logic [7:0] src_dis;
  logic [11:0] dom_dis;
  logic [2:0] main_sel;
  logic [31:0] async_src;
  logic [31:0] acon1;
  logic [31:0] ost_src;
  logic [31:0] pdiv;
  logic [31:0] stc_div;
  logic [31:0] pll1_a;
  logic [31:0] pll1_b;
  logic [31:0] pll2;
  logic [7:0] src_ok;
  logic hclk_raw;
  logic cpu_div;
  logic [2:0] p_raw;
  logic a3s_raw;
  logic a3d_raw;
  logic ost_raw;
  logic cpu_d1;
  logic slip1_flag;
  logic slip2_flag;
  logic slip1_req;
  logic slip2_req;
  logic clr_slip1;
  logic clr_slip2;
  logic [DATA_W-1:0] next_rd_data;
  cdg_tick_t next_tick;

  // Selected source tick; code 9 picks the primary peripheral tick, other codes above the source range give no clock
  function automatic logic pick(input logic [3:0] sel,
                                input logic [7:0] ok,
                                input logic periph);
    if (sel == SEL_PERIPH) begin
      return periph;
    end else if (sel[3]) begin
      return 1'b0;
    end
    return ok[sel[2:0]];
  endfunction

  function automatic logic [3:0] periph_div(input logic [1:0] code);
    case (code)
      PDIV_BY1: return 4'h0;
      PDIV_BY2: return 4'h1;
      PDIV_BY16: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic wr_hit(input cdg_req_t r,
                                  input logic [31:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // Register writes
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      src_dis <= SRC_DIS_RST;
      dom_dis <= DOM_DIS_RST;
      main_sel <= MAIN_SRC_RST;
    end else begin
      if (wr_hit(REG_REQ, OFS_SRC_DIS)) begin
        src_dis <= REG_REQ.wdata[7:0];
      end
      if (wr_hit(REG_REQ, OFS_DOM_DIS)) begin
        dom_dis <= REG_REQ.wdata[11:0];
      end
      if (wr_hit(REG_REQ, OFS_MAIN_SRC)) begin
        main_sel <= REG_REQ.wdata[2:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      async_src <= ASYNC_SRC_RST;
      acon1 <= ACON1_RST;
      ost_src <= OST_SRC_RST;
      pdiv <= ZERO_RST;
      stc_div <= ZERO_RST;
    end else begin
      if (wr_hit(REG_REQ, OFS_ASYNC_SRC)) begin
        async_src <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_ACON1)) begin
        acon1 <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_OST_SRC)) begin
        ost_src <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_PDIV)) begin
        pdiv <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_SELF_TEST_DIV)) begin
        stc_div <= REG_REQ.wdata;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pll1_a <= ZERO_RST;
      pll1_b <= ZERO_RST;
      pll2 <= ZERO_RST;
    end else begin
      if (wr_hit(REG_REQ, OFS_PLL1_A)) begin
        pll1_a <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_PLL1_B)) begin
        pll1_b <= REG_REQ.wdata;
      end
      if (wr_hit(REG_REQ, OFS_PLL2)) begin
        pll2 <= REG_REQ.wdata;
      end
    end
  end

  // PLL settings as seen by the analog macros
  always_comb begin
    PLL1_CFG.fm_en = pll1_b[PLL_FM];
    PLL1_CFG.slip_rst_en = pll1_a[PLL_SLIPRST];
    PLL1_CFG.mult = pll1_a[PLL_MULT_LSB +: 8];
    PLL1_CFG.prediv = pll1_a[PLL_DIV_LSB +: 3];
    PLL1_CFG.postdiv = pll1_b[PLL_DIV_LSB +: 3];
    PLL2_CFG.fm_en = 1'b0;
    PLL2_CFG.slip_rst_en = pll2[PLL_SLIPRST];
    PLL2_CFG.mult = pll2[PLL_MULT_LSB +: 8];
    PLL2_CFG.prediv = pll2[PLL_DIV_LSB +: 3];
    PLL2_CFG.postdiv = pll2[PLL_DIV_LSB + 4 +: 3];
  end

  // Source gating
  assign src_ok = SRC_TICK & ~src_dis;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SRC_ENABLE <= ~SRC_DIS_RST;
    end else begin
      SRC_ENABLE <= ~src_dis;
    end
  end

  assign hclk_raw = pick({1'b0, main_sel}, src_ok, 1'b0);

  // Self-test division; counter held clear outside self-test
  cdg_divider #(.W(3)) u_cpu_div (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .clr(!SELF_TEST_ACTIVE),
    .in_tick(hclk_raw),
    .div(stc_div[STC_DIV_LSB +: 3]),
    .out_tick(cpu_div)
  );

  for (genvar i = 0; i < 3; i++) begin : g_periph
    cdg_divider #(.W(4)) u_pdiv (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .clr(1'b0),
      .in_tick(hclk_raw),
      .div(periph_div(pdiv[PDIV_STRIDE*i +: 2])),
      .out_tick(p_raw[i])
    );
  end

  assign a3s_raw = pick(acon1[ACON_A3SEL_LSB +: 4], src_ok, p_raw[0]);

  cdg_divider #(.W(3)) u_a3_div (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .clr(1'b0),
    .in_tick(a3s_raw && !dom_dis[DD_A3]),
    .div(acon1[ACON_DIV_LSB +: 3]),
    .out_tick(a3d_raw)
  );

  // Prescale of 1, 2, 4 or 8 for the timer
  cdg_divider #(.W(3)) u_ost_div (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .clr(1'b0),
    .in_tick(pick(ost_src[OST_SEL_LSB +: 4], src_ok, p_raw[0])),
    .div(3'((4'h1 << ost_src[OST_PRE_LSB +: 2]) - 4'h1)),
    .out_tick(ost_raw)
  );

  // Gating acts on whole ticks, so a domain never sees a runt
  always_comb begin
    next_tick.bus = hclk_raw && !dom_dis[DD_BUS];
    next_tick.cpu = (SELF_TEST_ACTIVE ? cpu_div : hclk_raw)
                    && !dom_dis[DD_CPU];
    next_tick.cpu_dly = cpu_d1;
    next_tick.p1 = p_raw[0] && !dom_dis[DD_P1];
    next_tick.p2 = p_raw[1] && !dom_dis[DD_P2];
    next_tick.p3 = p_raw[2] && !dom_dis[DD_P3];
    next_tick.a1 = pick(async_src[ASRC_A1_LSB +: 4], src_ok, p_raw[0])
                   && !dom_dis[DD_A1];
    next_tick.a2 = pick(async_src[ASRC_A2_LSB +: 4], src_ok, p_raw[0])
                   && !dom_dis[DD_A2];
    next_tick.a3s = a3s_raw && !dom_dis[DD_A3];
    next_tick.a3d = a3d_raw && !acon1[ACON_GATE];
    next_tick.a4 = pick(acon1[ACON_A4SEL_LSB +: 4], src_ok, p_raw[0])
                   && !dom_dis[DD_A4];
    next_tick.ost = ost_raw && !dom_dis[DD_OST];
  end

  // The delayed copy follows the CPU tick, so it shares gate and division
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cpu_d1 <= 1'b0;
      DOMAIN_TICK <= '0;
    end else begin
      cpu_d1 <= DOMAIN_TICK.cpu;
      DOMAIN_TICK <= next_tick;
    end
  end

  // Slip monitoring
  assign clr_slip1 = wr_hit(REG_REQ, OFS_STATUS) && REG_REQ.wdata[STAT_SLIP1];
  assign clr_slip2 = wr_hit(REG_REQ, OFS_STATUS) && REG_REQ.wdata[STAT_SLIP2];

  cdg_slip_monitor u_slip1 (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .slip(PLL1_SLIP),
    .clr(clr_slip1),
    .reset_en(pll1_a[PLL_SLIPRST]),
    .flag(slip1_flag),
    .reset_req(slip1_req)
  );

  cdg_slip_monitor u_slip2 (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .slip(PLL2_SLIP),
    .clr(clr_slip2),
    .reset_en(pll2[PLL_SLIPRST]),
    .flag(slip2_flag),
    .reset_req(slip2_req)
  );

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DEVICE_RESET_REQ <= 1'b0;
    end else begin
      DEVICE_RESET_REQ <= slip1_req || slip2_req;
    end
  end

  // Read path; unmapped addresses read zero
  always_comb begin
    next_rd_data = '0;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        OFS_SRC_DIS: next_rd_data = {24'h000000, src_dis};
        OFS_DOM_DIS: next_rd_data = {20'h00000, dom_dis};
        OFS_MAIN_SRC: next_rd_data = {29'h00000000, main_sel};
        OFS_ASYNC_SRC: next_rd_data = async_src;
        OFS_ACON1: next_rd_data = acon1;
        OFS_OST_SRC: next_rd_data = ost_src;
        OFS_PDIV: next_rd_data = pdiv;
        OFS_SELF_TEST_DIV: next_rd_data = stc_div;
        OFS_PLL1_A: next_rd_data = pll1_a;
        OFS_PLL1_B: next_rd_data = pll1_b;
        OFS_PLL2: next_rd_data = pll2;
        OFS_STATUS: next_rd_data = {22'h000000, slip2_flag, slip1_flag,
                                    src_ok};
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= '0;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  chk_cpu_gate: assert property (
    DOMAIN_TICK.cpu |-> $past(hclk_raw) && !$past(dom_dis[DD_CPU]))
    else $error("cpu tick out of phase or while gated");

  chk_bus_gate: assert property (
    $past(hclk_raw) && !$past(dom_dis[DD_BUS]) |-> DOMAIN_TICK.bus)
    else $error("bus tick missing");

  chk_cpu_bypass: assert property (
    $past(!SELF_TEST_ACTIVE && hclk_raw && !dom_dis[DD_CPU])
    |-> DOMAIN_TICK.cpu)
    else $error("cpu tick missing outside self-test");

  sequence s_cpu_tick;
    DOMAIN_TICK.cpu;
  endsequence

  chk_cpu_delay: assert property (
    s_cpu_tick |-> ##2 DOMAIN_TICK.cpu_dly)
    else $error("delayed cpu tick not two cycles later");

  chk_dly_only: assert property (
    DOMAIN_TICK.cpu_dly |-> $past(DOMAIN_TICK.cpu, 2))
    else $error("delayed cpu tick without cpu tick");

  chk_periph_gate: assert property (
    DOMAIN_TICK.p1 || DOMAIN_TICK.p2 || DOMAIN_TICK.p3
    |-> $past(hclk_raw))
    else $error("peripheral tick not aligned with bus source");

  chk_a3_half: assert property (
    (a3d_raw && acon1[ACON_DIV_LSB +: 3] == 3'h1) |=> !a3d_raw)
    else $error("divided async three tick too fast");

  chk_a3d_gate: assert property (
    DOMAIN_TICK.a3d |-> !$past(acon1[ACON_GATE]) && !$past(dom_dis[DD_A3]))
    else $error("divided async three tick while gated");

  chk_pll2_no_fm: assert property (
    !PLL2_CFG.fm_en)
    else $error("second pll modulation enabled");

  chk_slip_reset: assert property (
    PLL1_SLIP && pll1_a[PLL_SLIPRST] |-> ##2 DEVICE_RESET_REQ)
    else $error("slip did not request device reset");

  chk_src_dis: assert property (
    DOMAIN_TICK.bus |-> !$past(src_dis[main_sel]))
    else $error("bus tick from disabled source");

endmodule // cdg_top

//--- test/cdg_top_test.sv
`timescale 1ns/1ps
module cdg_top_test
  import cdg_pkg::*;
;
  logic SYS_CLK, RST_B, SELF_TEST_ACTIVE, PLL1_SLIP, PLL2_SLIP;
  logic DEVICE_RESET_REQ;
  cdg_req_t REG_REQ;
  logic [7:0] SRC_TICK, SRC_ENABLE;
  logic [DATA_W-1:0] RD_DATA, rv;
  cdg_tick_t DOMAIN_TICK;
  cdg_pll_cfg_t PLL1_CFG, PLL2_CFG;
  int error_cnt = 0;
  int total_checks = 0;
  // Tick counters indexed by bit of DOMAIN_TICK: bus 11 ... ost 0
  int cnt[12];

  cdg_top i_dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_REQ(REG_REQ),
    .RD_DATA(RD_DATA), .SRC_TICK(SRC_TICK),
    .SELF_TEST_ACTIVE(SELF_TEST_ACTIVE), .PLL1_SLIP(PLL1_SLIP),
    .PLL2_SLIP(PLL2_SLIP), .DOMAIN_TICK(DOMAIN_TICK),
    .SRC_ENABLE(SRC_ENABLE), .PLL1_CFG(PLL1_CFG), .PLL2_CFG(PLL2_CFG),
    .DEVICE_RESET_REQ(DEVICE_RESET_REQ));

  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  always @(posedge SYS_CLK) begin
    for (int i = 0; i < 12; i++) begin
      if (DOMAIN_TICK[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic ck(input string nm, input int idx, input int exp);
    chk(nm, exp, cnt[idx]);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    REG_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge SYS_CLK);
    REG_REQ.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge SYS_CLK);
    REG_REQ <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge SYS_CLK);
    REG_REQ.rd <= 1'b0;
    @(negedge SYS_CLK);
    rv = RD_DATA;
  endtask

  // Tail of four idle cycles lets the delayed CPU tick land in the count
  task automatic run(input int n, input logic [7:0] m);
    @(negedge SYS_CLK);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge SYS_CLK);
      SRC_TICK <= m;
    end
    @(posedge SYS_CLK);
    SRC_TICK <= 8'h00;
    repeat (4) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask

  task automatic t_reset();
    logic [31:0] ad[8] = '{OFS_SRC_DIS, OFS_DOM_DIS, OFS_MAIN_SRC,
      OFS_ASYNC_SRC, OFS_OST_SRC, OFS_ACON1, OFS_SELF_TEST_DIV,
      32'hffffe100};
    logic [31:0] ex[8] = '{32'h000000ce, 32'h0, 32'h0, 32'h00000909,
      32'h00000009, 32'h00090109, 32'h0, 32'h0};
    chk("source enable", 32'h31, {24'h0, SRC_ENABLE});
    for (int k = 0; k < 8; k++) begin
      rd(ad[k]);
      chk("reset value", ex[k], rv);
    end
  endtask

  task automatic t_main();
    run(8, 8'h01);
    for (int i = 0; i < 12; i++) begin
      ck("tick count", i, (i == 2) ? 4 : 8);
    end
  endtask

  task automatic t_gate();
    int ddb[10] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 11};
    int fa[10] = '{10, 11, 8, 7, 5, 4, 0, 6, 3, 1};
    int fb[10] = '{9, 11, 8, 7, 5, 4, 0, 6, 2, 1};
    for (int k = 0; k < 10; k++) begin
      wr(OFS_DOM_DIS, 32'h1 << ddb[k]);
      run(8, 8'h01);
      ck("gated domain", fa[k], 0);
      ck("gated companion", fb[k], 0);
      ck("ungated reference", (k == 1) ? 10 : 11, 8);
    end
    wr(OFS_DOM_DIS, 32'h0);
  endtask

  task automatic t_acon();
    wr(OFS_ACON1, 32'h00090119);
    run(8, 8'h01);
    ck("async three source", 3, 8);
    ck("async three divided", 2, 0);
    wr(OFS_ACON1, 32'h00090709);
    run(16, 8'h01);
    ck("async three by eight", 2, 2);
    wr(OFS_ACON1, ACON1_RST);
  endtask

  // Second peripheral kept a multiple of the first, as software must
  task automatic t_pdiv();
    wr(OFS_PDIV, 32'h00000102);
    run(64, 8'h01);
    ck("bus", 11, 64);
    ck("periph one", 8, 4);
    ck("periph two", 7, 32);
    ck("periph three", 6, 64);
    ck("async one", 5, 4);
    ck("async four", 1, 4);
    ck("os timer", 0, 4);
    ck("async three divided", 2, 2);
    wr(OFS_PDIV, 32'h0);
  endtask

  task automatic t_self();
    int f[3] = '{0, 3, 7};
    @(posedge SYS_CLK);
    SELF_TEST_ACTIVE <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wr(OFS_SELF_TEST_DIV, f[k]);
      run(16, 8'h01);
      ck("cpu self test", 10, 16 / (f[k] + 1));
      ck("cpu delayed self test", 9, 16 / (f[k] + 1));
      ck("bus self test", 11, 16);
    end
    @(posedge SYS_CLK);
    SELF_TEST_ACTIVE <= 1'b0;
  endtask

  task automatic t_src();
    wr(OFS_SRC_DIS, 32'hcf);
    // The enable output is registered one edge behind the register
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    chk("source enable", 32'h30, {24'h0, SRC_ENABLE});
    run(8, 8'h01);
    ck("disabled source", 11, 0);
    wr(OFS_SRC_DIS, 32'hce);
    wr(OFS_MAIN_SRC, 32'h4);
    run(8, 8'h10);
    ck("main select four", 11, 8);
    run(8, 8'h01);
    ck("main select old", 11, 0);
    wr(OFS_MAIN_SRC, 32'h0);
  endtask

  // External input one as a square wave; timer on it kept below a third
  task automatic t_ext();
    wr(OFS_SRC_DIS, 32'hc6);
    wr(OFS_MAIN_SRC, 32'h3);
    wr(OFS_OST_SRC, 32'h00000203);
    @(negedge SYS_CLK);
    cnt = '{default: 0};
    for (int k = 0; k < 16; k++) begin
      @(posedge SYS_CLK);
      SRC_TICK <= (k % 2 == 0) ? 8'h08 : 8'h00;
    end
    @(posedge SYS_CLK);
    SRC_TICK <= 8'h00;
    repeat (4) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    ck("external source bus", 11, 8);
    ck("periph one external", 8, 8);
    ck("timer foreign source", 0, 2);
    wr(OFS_OST_SRC, OST_SRC_RST);
    wr(OFS_MAIN_SRC, 32'h0);
    wr(OFS_SRC_DIS, 32'hce);
  endtask

  task automatic t_lag();
    @(posedge SYS_CLK);
    SRC_TICK <= 8'h01;
    @(posedge SYS_CLK);
    SRC_TICK <= 8'h00;
    @(negedge SYS_CLK);
    chk("bus cpu pair", 32'h3,
      {30'h0, DOMAIN_TICK.bus, DOMAIN_TICK.cpu});
    chk("delayed early", 32'h0, {31'h0, DOMAIN_TICK.cpu_dly});
    @(negedge SYS_CLK);
    chk("delayed mid", 32'h0, {31'h0, DOMAIN_TICK.cpu_dly});
    @(negedge SYS_CLK);
    chk("delayed lag", 32'h1, {31'h0, DOMAIN_TICK.cpu_dly});
  endtask

  // A slip cannot show before two edges, so the window is fixed at six
  task automatic slip(input int which, input logic rst_exp);
    logic seen;
    seen = 1'b0;
    @(posedge SYS_CLK);
    if (which == 1) PLL1_SLIP <= 1'b1;
    else PLL2_SLIP <= 1'b1;
    @(posedge SYS_CLK);
    PLL1_SLIP <= 1'b0;
    PLL2_SLIP <= 1'b0;
    repeat (6) begin
      @(negedge SYS_CLK);
      if (DEVICE_RESET_REQ === 1'b1) seen = 1'b1;
    end
    chk("slip reset request", {31'h0, rst_exp}, {31'h0, seen});
    rd(OFS_STATUS);
    chk("slip flag", 32'h1, {31'h0, rv[STAT_SLIP1 + which - 1]});
    wr(OFS_STATUS, 32'h1 << (STAT_SLIP1 + which - 1));
    rd(OFS_STATUS);
    chk("slip flag cleared", 32'h0,
      {31'h0, rv[STAT_SLIP1 + which - 1]});
  endtask

  task automatic t_pll();
    wr(OFS_PLL1_A, 32'h80000a05);
    wr(OFS_PLL1_B, 32'h80000003);
    wr(OFS_PLL2, 32'hffffffff);
    @(negedge SYS_CLK);
    chk("pll one modulation", 32'h3, {30'h0, PLL1_CFG.fm_en,
      PLL1_CFG.slip_rst_en});
    chk("pll one config", 32'h000002ab,
      {18'h0, PLL1_CFG.mult, PLL1_CFG.prediv, PLL1_CFG.postdiv});
    chk("pll two modulation", 32'h0, {31'h0, PLL2_CFG.fm_en});
    chk("pll two mult", 32'hff, {24'h0, PLL2_CFG.mult});
    chk("pll two dividers", 32'h3f,
      {26'h0, PLL2_CFG.prediv, PLL2_CFG.postdiv});
    slip(1, 1'b1);
    slip(2, 1'b1);
    wr(OFS_PLL1_A, 32'h0);
    slip(1, 1'b0);
  endtask

  initial begin
    #(40 * 50000);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    RST_B = 1'b0;
    REG_REQ = '0;
    SRC_TICK = 8'h00;
    SELF_TEST_ACTIVE = 1'b0;
    PLL1_SLIP = 1'b0;
    PLL2_SLIP = 1'b0;
    repeat (12) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    t_reset();
    t_main();
    t_gate();
    t_acon();
    t_pdiv();
    t_self();
    t_src();
    t_ext();
    t_lag();
    t_pll();
    end_sim();
  end
endmodule // cdg_top_test
